/* File: rtl/lds_pkg.sv */
// Shared constants and types of the lift deceleration and stop sequencer
package lds_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS   = 25;
    localparam int TICK_TIME_NS    = 1_000_000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

    // Widths
    localparam int SPD_W  = 26;
    localparam int SET_W  = 16;
    localparam int TIME_W = 16;
    localparam int PATH_W = 32;

    // Speed settings are mm/s, the setpoint is um/s
    localparam int UM_PER_MM = 1000;

    // Speed levels, index of the select inputs plus one
    localparam logic [1:0] LVL_ZERO  = 2'h0;
    localparam logic [1:0] LVL_CREEP = 2'h1;
    localparam logic [1:0] LVL_MID   = 2'h2;
    localparam logic [1:0] LVL_HIGH  = 2'h3;

    // Reset values and divide step count
    localparam logic [TIME_W-1:0] PHASE_CNT_RST = 16'h0000;
    localparam logic [1:0]        CAP_RST       = 2'h3;
    localparam int                DIV_STEPS     = 32;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RUN     = 3'b001,
        ST_HOLD0   = 3'b010,
        ST_BRAKE   = 3'b011,
        ST_EXTRA   = 3'b100,
        ST_CURLESS = 3'b101,
        ST_CONT    = 3'b110
    } lds_state_e;

endpackage

/* File: rtl/lds_cutoff_delay.sv */
// Stretches the withdrawal of one speed select by a delay in ms ticks
`timescale 1ns/1ps
module lds_cutoff_delay
    import lds_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              tick,
    input  wire logic              sel_in,
    input  wire logic [TIME_W-1:0] delay_ms,
    output logic                   sel_out
);

    logic [TIME_W-1:0] cnt_r;

    // Assertion passes at once; withdrawal waits out the delay
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_out <= 1'b0;
            cnt_r   <= PHASE_CNT_RST;
        end else if (sel_in) begin
            sel_out <= 1'b1;
            cnt_r   <= PHASE_CNT_RST;
        end else if (sel_out) begin
            if (cnt_r >= delay_ms) begin
                sel_out <= 1'b0;
            end else if (tick) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

endmodule

/* File: rtl/lds_sequencer.sv */
// Time-dependent deceleration and stop sequencer of a lift drive
//
// Notes on behaviour
// [R01] Deceleration-mode select low: every speed change ramps time-dependently.
// [R02] On withdrawal ramp to highest still-selected speed with rate and rounding.
// [R03] High reached: withdrawing high ramps to mid, withdrawing mid to creep.
// [R04] High not reached at cut-off: decelerate and travel at creep.
// [R05] Creep withdrawn: keep decelerating down to zero speed.
// [R06] At zero speed drop brake release while motor stays energized.
// [R07] After brake phase cut motor current, then drop drive ready.
// [R08] Outside control must open safe torque off or contactors when ready drops.
// [R09] Rate sets ramp slope; upper and lower rounding soften the corners.
// [R10] Settings change recomputes high-to-creep path for display.
// [R11] Creep, mid and high withdrawals are delayed by their cut-off delays.
// [R12] Stop phases: hold zero, brake wait plus extra current, currentless, contactors.
// [R13] Brake monitoring with feedback ends brake wait early, goes to currentless.
// [R14] Contactor monitoring with feedback ends contactor wait early.
// [R15] After a speed drop, higher requests ignored until all off at zero.
// [R16] Without monitoring a wait phase runs its full time.
`timescale 1ns/1ps
module lds_sequencer
    import lds_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              drive_enable_in,
    input  wire logic [1:0]        direction_select_in,
    input  wire logic [2:0]        speed_select_in,
    input  wire logic              brake_closed_fb_in,
    input  wire logic              contactor_open_fb_in,
    input  wire logic              decel_mode_select,
    input  wire logic [SET_W-1:0]  creep_speed_setting,
    input  wire logic [SET_W-1:0]  mid_speed_setting,
    input  wire logic [SET_W-1:0]  high_speed_setting,
    input  wire logic [SET_W-1:0]  decel_rate_setting,
    input  wire logic [3:0]        upper_rounding_setting,
    input  wire logic [3:0]        lower_rounding_setting,
    input  wire logic [TIME_W-1:0] creep_cutoff_delay,
    input  wire logic [TIME_W-1:0] mid_cutoff_delay,
    input  wire logic [TIME_W-1:0] high_cutoff_delay,
    input  wire logic [TIME_W-1:0] hold_zero_time,
    input  wire logic [TIME_W-1:0] brake_wait_time,
    input  wire logic [TIME_W-1:0] extra_current_time,
    input  wire logic [TIME_W-1:0] currentless_wait_time,
    input  wire logic [TIME_W-1:0] contactor_wait_time,
    input  wire logic              brake_monitor_select,
    input  wire logic              brake_fb_present,
    input  wire logic              contactor_monitor_select,
    input  wire logic              contactor_fb_present,
    output logic                   brake_release_out,
    output logic                   drive_ready_out,
    output logic                   motor_current_out,
    output logic [SPD_W-1:0]       speed_setpoint_out,
    output logic [1:0]             direction_out,
    output logic [SET_W-1:0]       decel_path_out,
    output logic                   stop_done_out
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {contactor_open_fb_in, brake_closed_fb_in,
                           direction_select_in, drive_enable_in,
                           speed_select_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    logic [2:0] sel_sync;
    logic       enable_s;
    logic [1:0] dir_s;
    logic       brake_fb_s;
    logic       cont_fb_s;

    assign sel_sync   = pin_sync_r[2:0];
    assign enable_s   = pin_sync_r[3];
    assign dir_s      = pin_sync_r[5:4];
    assign brake_fb_s = pin_sync_r[6];
    assign cont_fb_s  = pin_sync_r[7];

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick; count exceeds 4096 so it is a parameter
    logic [31:0] tick_cnt_r;
    logic        tick_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cut-off delays, one per speed select
    logic [2:0]        sel_eff;
    for (genvar g = 0; g < 3; g++) begin : g_cut
        lds_cutoff_delay u_cut (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .tick     (tick_r),
            .sel_in   (sel_sync[g]),
            .delay_ms ((g == 0) ? creep_cutoff_delay
                       : (g == 1) ? mid_cutoff_delay : high_cutoff_delay),
            .sel_out  (sel_eff[g])
        ); // [R11]
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed level selection
    function automatic logic [1:0] top_level(input logic [2:0] s,
                                             input logic [1:0] cap);
        logic [1:0] l;
        l = LVL_ZERO;
        if (s[2] && cap >= LVL_HIGH) begin
            l = LVL_HIGH;
        end else if (s[1] && cap >= LVL_MID) begin
            l = LVL_MID;
        end else if (s[0] && cap >= LVL_CREEP) begin
            l = LVL_CREEP;
        end
        return l;
    endfunction

    function automatic logic [SPD_W-1:0] level_um(input logic [1:0] l,
        input logic [SET_W-1:0] c, input logic [SET_W-1:0] m,
        input logic [SET_W-1:0] h);
        logic [SET_W-1:0] mm;
        mm = '0;
        case (l)
            LVL_CREEP: mm = c;
            LVL_MID:   mm = m;
            LVL_HIGH:  mm = h;
            default:   mm = '0;
        endcase
        return SPD_W'(mm * UM_PER_MM);
    endfunction

    lds_state_e        state_r;
    logic [1:0]        cap_r;
    logic [1:0]        level_r;
    logic              high_reached_r;
    logic [1:0]        level_now;
    logic [SPD_W-1:0]  target_um;

    assign level_now = top_level(sel_eff, cap_r);
    assign target_um = level_um(level_r, creep_speed_setting,
                                mid_speed_setting, high_speed_setting);

    // Ceiling drops with each fall of the selected level; reopened only at standstill
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_r          <= CAP_RST;
            level_r        <= LVL_ZERO;
            high_reached_r <= 1'b0;
        end else if (state_r != ST_RUN) begin
            cap_r          <= CAP_RST; // [R15]
            level_r        <= LVL_ZERO;
            high_reached_r <= 1'b0;
        end else begin
            if (level_r == LVL_HIGH && speed_setpoint_out == target_um) begin
                high_reached_r <= 1'b1;
            end
            if (level_now < level_r) begin
                if (level_r == LVL_HIGH && !high_reached_r
                        && level_now != LVL_ZERO) begin
                    level_r <= LVL_CREEP; // [R04]
                    cap_r   <= LVL_CREEP; // [R04]
                end else begin
                    level_r <= level_now; // [R02] [R03] [R05]
                    cap_r   <= level_now; // [R15]
                end
            end else begin
                level_r <= level_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rounded deceleration ramp, updated once per ms
    logic [SET_W-1:0] decel_now_r;
    logic [SPD_W-1:0] diff_dn;
    logic [SPD_W-1:0] diff_up;
    logic [SET_W-1:0] jerk;
    logic [31:0]      taper_zone;
    logic [SET_W-1:0] decel_nxt;

    assign diff_dn    = speed_setpoint_out - target_um;
    assign diff_up    = target_um - speed_setpoint_out;
    assign taper_zone = {16'h0000, decel_now_r} << lower_rounding_setting;

    always_comb begin
        jerk = decel_rate_setting >> upper_rounding_setting; // [R09]
        if (jerk == '0) begin
            jerk = 16'h0001;
        end
        if ({6'h00, diff_dn} <= taper_zone) begin
            decel_nxt = (decel_now_r > jerk) ? decel_now_r - jerk : jerk;
        end else if ({1'b0, decel_now_r} + {1'b0, jerk}
                     >= {1'b0, decel_rate_setting}) begin
            decel_nxt = decel_rate_setting; // [R09]
        end else begin
            decel_nxt = decel_now_r + jerk;
        end
    end

    // Going up uses a plain linear slope; start-up shaping is not modelled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            speed_setpoint_out <= '0;
            decel_now_r        <= '0;
        end else if (state_r != ST_RUN) begin
            speed_setpoint_out <= '0;
            decel_now_r        <= '0;
        end else if (tick_r) begin
            if (speed_setpoint_out > target_um) begin
                decel_now_r <= decel_nxt; // [R01]
                if ({10'h000, decel_nxt} >= diff_dn) begin
                    speed_setpoint_out <= target_um;
                end else begin
                    speed_setpoint_out <= speed_setpoint_out
                                          - {10'h000, decel_nxt};
                end
            end else begin
                decel_now_r <= '0;
                if ({10'h000, decel_rate_setting} >= diff_up) begin
                    speed_setpoint_out <= target_um;
                end else begin
                    speed_setpoint_out <= speed_setpoint_out
                                          + {10'h000, decel_rate_setting};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop sequence
    logic [TIME_W-1:0] phase_cnt_r;
    logic [TIME_W-1:0] phase_len;
    logic              start_req;
    logic              stop_req;
    logic              brake_early;
    logic              cont_early;
    lds_state_e        adv;
    lds_state_e        state_nxt;

    // Distance mode is not built here, so travel only starts with it off
    assign start_req = enable_s && (dir_s != 2'h0) && (sel_eff != 3'h0)
                       && !decel_mode_select; // [R01]
    assign stop_req = (level_r == LVL_ZERO) && (speed_setpoint_out == '0)
                      && (level_now == LVL_ZERO); // [R05]
    assign brake_early = brake_monitor_select && brake_fb_present
                         && brake_fb_s; // [R13]
    assign cont_early = contactor_monitor_select && contactor_fb_present
                        && cont_fb_s; // [R14]

    // Phases are coded in order, so a timed phase simply steps on
    always_comb begin
        case (state_r)
            ST_HOLD0:   phase_len = hold_zero_time;
            ST_BRAKE:   phase_len = brake_wait_time;
            ST_EXTRA:   phase_len = extra_current_time;
            ST_CURLESS: phase_len = currentless_wait_time;
            default:    phase_len = contactor_wait_time;
        endcase
        adv = state_r;
        if (phase_cnt_r >= phase_len) begin
            adv = (state_r == ST_CONT) ? ST_IDLE
                : lds_state_e'(state_r + 3'h1); // [R12] [R16]
        end
        case (state_r)
            ST_IDLE:  state_nxt = start_req ? ST_RUN : ST_IDLE;
            ST_RUN:   state_nxt = stop_req ? ST_HOLD0 : ST_RUN; // [R12]
            ST_BRAKE: state_nxt = brake_early ? ST_CURLESS : adv; // [R13]
            ST_CONT:  state_nxt = cont_early ? ST_IDLE : adv; // [R14]
            default:  state_nxt = adv; // [R07]
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            phase_cnt_r <= PHASE_CNT_RST;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r || state_r inside {ST_IDLE, ST_RUN}) begin
                phase_cnt_r <= PHASE_CNT_RST;
            end else if (tick_r) begin
                phase_cnt_r <= phase_cnt_r + 16'h0001;
            end
        end
    end

    // Outputs follow the state one cycle later, all from flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brake_release_out <= 1'b0;
            motor_current_out <= 1'b0;
            drive_ready_out   <= 1'b0;
            direction_out     <= 2'h0;
            stop_done_out     <= 1'b0;
        end else begin
            brake_release_out <= (state_r == ST_RUN); // [R06]
            motor_current_out <= state_r inside {[ST_RUN:ST_EXTRA]}; // [R07]
            drive_ready_out   <= state_r inside {[ST_RUN:ST_CURLESS]}; // [R07]
            direction_out     <= (state_r == ST_RUN) ? dir_s : 2'h0;
            stop_done_out     <= (state_r == ST_CONT)
                && (state_nxt == ST_IDLE); // [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // High-to-creep path in mm, (vh^2 - vc^2) / (2a), serial divide
    logic [47:0]       seen_r;
    logic [5:0]        div_cnt_r;
    logic [PATH_W-1:0] quo_r;
    logic [PATH_W:0]   rem_r;
    logic [PATH_W:0]   rem_sh;
    logic [PATH_W-1:0] num;
    logic [SET_W:0]    den;
    logic              settings_moved;

    assign num = (high_speed_setting > creep_speed_setting)
        ? PATH_W'(high_speed_setting * high_speed_setting)
          - PATH_W'(creep_speed_setting * creep_speed_setting)
        : '0;
    assign den    = {decel_rate_setting, 1'b0};
    assign rem_sh = {rem_r[PATH_W-1:0], quo_r[PATH_W-1]};
    assign settings_moved = seen_r != {decel_rate_setting,
        high_speed_setting, creep_speed_setting};

    // A change mid-divide restarts it, so the display never shows a mix
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seen_r         <= '0;
            div_cnt_r      <= '0;
            quo_r          <= '0;
            rem_r          <= '0;
            decel_path_out <= '0;
        end else if (settings_moved) begin
            seen_r       <= {decel_rate_setting, high_speed_setting,
                             creep_speed_setting}; // [R10]
            quo_r        <= num;
            rem_r        <= '0;
            div_cnt_r    <= 6'(DIV_STEPS);
        end else if (div_cnt_r != '0) begin
            div_cnt_r <= div_cnt_r - 6'h01;
            if (rem_sh >= {16'h0000, den}) begin
                rem_r <= rem_sh - {16'h0000, den};
                quo_r <= {quo_r[PATH_W-2:0], 1'b1};
            end else begin
                rem_r <= rem_sh;
                quo_r <= {quo_r[PATH_W-2:0], 1'b0};
            end
        end else if (den == '0) begin
            decel_path_out <= '1;
        end else if (quo_r[PATH_W-1:SET_W] != '0) begin
            decel_path_out <= '1; // [R10]
        end else begin
            decel_path_out <= quo_r[SET_W-1:0]; // [R10]
        end
    end

endmodule

/* File: bench/lds_sequencer_assertions.sv */
// Port-level checks of the deceleration and stop sequencer
`timescale 1ns/1ps
module lds_seq_chk
    import lds_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              decel_mode_select,
    input wire logic [SET_W-1:0]  decel_rate_setting,
    input wire logic [TIME_W-1:0] contactor_wait_time,
    input wire logic              contactor_monitor_select,
    input wire logic              contactor_fb_present,
    input wire logic              contactor_open_fb_in,
    input wire logic              brake_release_out,
    input wire logic              drive_ready_out,
    input wire logic              motor_current_out,
    input wire logic [SPD_W-1:0]  speed_setpoint_out,
    input wire logic              stop_done_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [31:0] low_cnt_r;
    ////////////////////////////////////////////////////////////////////////
    // Saturates so a long idle spell cannot wrap into a false match
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst || drive_ready_out) begin
            low_cnt_r <= 32'h0000_0000;
        end else if (low_cnt_r != 32'hFFFF_FFFF) begin
            low_cnt_r <= low_cnt_r + 32'h0000_0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    mode_refuse_a: assert property (
        $past(decel_mode_select) && decel_mode_select
        |-> !$rose(drive_ready_out))
        else $error("ready rose in distance mode");
    start_together_a: assert property (
        $rose(drive_ready_out) |-> brake_release_out && motor_current_out)
        else $error("start outputs not together");
    brake_at_zero_a: assert property (
        $fell(brake_release_out) |-> motor_current_out && drive_ready_out
        && speed_setpoint_out == '0)
        else $error("brake dropped off zero or unpowered");
    zero_while_held_a: assert property (
        !brake_release_out |-> speed_setpoint_out == '0)
        else $error("setpoint nonzero with brake held");
    current_first_a: assert property (
        $fell(motor_current_out) |-> drive_ready_out)
        else $error("ready gone before current cut");
    done_pulse_a: assert property (
        stop_done_out |-> !drive_ready_out && !motor_current_out
        ##1 !stop_done_out)
        else $error("stop done not a clean pulse");
    cont_early_a: assert property (
        $rose(contactor_open_fb_in) && contactor_monitor_select
        && contactor_fb_present |-> ##[1:6] stop_done_out)
        else $error("contactor feedback did not end stop");
    cont_full_a: assert property (
        stop_done_out && !contactor_monitor_select
        |-> low_cnt_r + 2 >= contactor_wait_time * TICK_CYCLES
        && low_cnt_r <= (contactor_wait_time + 1) * TICK_CYCLES + 3)
        else $error("contactor wait length wrong");
    rate_limit_a: assert property (
        speed_setpoint_out < $past(speed_setpoint_out)
        |-> $past(speed_setpoint_out) - speed_setpoint_out
        <= decel_rate_setting)
        else $error("ramp steeper than rate");
endmodule
bind lds_sequencer lds_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .ref_clk, .rst, .decel_mode_select, .decel_rate_setting,
    .contactor_wait_time, .contactor_monitor_select, .contactor_fb_present,
    .contactor_open_fb_in, .brake_release_out, .drive_ready_out,
    .motor_current_out, .speed_setpoint_out, .stop_done_out);

/* File: bench/lds_lift_ctrl.sv */
// Lift control and plant model: speed pins, brake and contactor feedback
`timescale 1ns/1ps
module lds_lift_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [2:0] sel_req,
    input  wire logic [1:0] dir_req,
    input  wire logic [7:0] brake_dly,
    input  wire logic       brake_release_out,
    input  wire logic       drive_ready_out,
    output logic            drive_enable_in,
    output logic [1:0]      direction_select_in,
    output logic [2:0]      speed_select_in,
    output logic            brake_closed_fb_in,
    output logic            contactor_open_fb_in
);
    logic [7:0] brk_cnt_r;
    ////////////////////////////////////////////////////////////////////////
    // Brake feedback comes brake_dly+1 cycles after release drops; slow values stress the wait
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brk_cnt_r <= 8'h00;
            drive_enable_in <= 1'b0;
            direction_select_in <= 2'h0;
            speed_select_in <= 3'h0;
            brake_closed_fb_in <= 1'b1;
            contactor_open_fb_in <= 1'b1;
        end else begin
            speed_select_in <= sel_req;
            direction_select_in <= dir_req;
            drive_enable_in <= (sel_req != 3'h0) || drive_ready_out;
            contactor_open_fb_in <= !drive_ready_out;
            if (brake_release_out) begin
                brk_cnt_r <= 8'h00;
            end else if (brk_cnt_r != brake_dly) begin
                brk_cnt_r <= brk_cnt_r + 8'h01;
            end
            brake_closed_fb_in <= !brake_release_out && brk_cnt_r == brake_dly;
        end
    end
endmodule

/* File: bench/test_lds_sequencer.sv */
// Directed bench of the deceleration and stop sequencer
`timescale 1ns/1ps
module test_lds_sequencer;
    import lds_pkg::*;
    localparam int TC = 4;
    logic ref_clk = 1'b0, rst = 1'b1, decel_mode_select = 1'b0;
    logic [2:0] sel_req = 3'h0;
    logic [1:0] dir_req = 2'h1, direction_select_in, direction_out;
    logic [7:0] brake_dly = 8'h01;
    logic brake_monitor_select = 1'b0, brake_fb_present = 1'b1;
    logic contactor_monitor_select = 1'b0, contactor_fb_present = 1'b1;
    logic [SET_W-1:0] creep_speed_setting = 16'h0064, decel_path_out;
    logic [SET_W-1:0] mid_speed_setting = 16'h0190;
    logic [SET_W-1:0] high_speed_setting = 16'h03E8;
    logic [SET_W-1:0] decel_rate_setting = 16'h0FA0;
    logic [3:0] upper_rounding_setting = 4'h0, lower_rounding_setting = 4'h0;
    logic [TIME_W-1:0] creep_cutoff_delay = 16'h0001;
    logic [TIME_W-1:0] mid_cutoff_delay = 16'h0001;
    logic [TIME_W-1:0] high_cutoff_delay = 16'h0003;
    logic [TIME_W-1:0] hold_zero_time = 16'h0002, brake_wait_time = 16'h0014;
    logic [TIME_W-1:0] extra_current_time = 16'h0003;
    logic [TIME_W-1:0] currentless_wait_time = 16'h0002;
    logic [TIME_W-1:0] contactor_wait_time = 16'h000A;
    logic drive_enable_in, brake_closed_fb_in, contactor_open_fb_in;
    logic [2:0] speed_select_in;
    logic brake_release_out, drive_ready_out, motor_current_out, stop_done_out;
    logic [SPD_W-1:0] speed_setpoint_out;
    int bad_count = 0, samples_checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    lds_lift_ctrl lift (.ref_clk, .rst, .sel_req, .dir_req, .brake_dly,
        .brake_release_out, .drive_ready_out, .drive_enable_in,
        .direction_select_in, .speed_select_in, .brake_closed_fb_in,
        .contactor_open_fb_in);
    lds_sequencer #(.TICK_CYCLES(TC)) uut (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic check_in(input string what, input int lo, input int hi,
                            input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic hit(input int k, input logic [31:0] v);
        case (k)
            0: hit = speed_setpoint_out == v[SPD_W-1:0];
            1: hit = !brake_release_out;
            2: hit = !motor_current_out;
            3: hit = !drive_ready_out;
            default: hit = stop_done_out;
        endcase
    endfunction
    task automatic wait_on(input int k, input logic [31:0] v, output int n);
        n = 0;
        while (hit(k, v) !== 1'b1) begin
            step(1);
            n++;
            if (n > 4000) begin
                bad_count++;
                $display("[ERR] wait %0d expected 1 seen 0", k);
                results();
            end
        end
    endtask
    function automatic logic [31:0] path_mm();
        int h, c;
        h = high_speed_setting;
        c = creep_speed_setting;
        return (h * h - c * c) / (2 * decel_rate_setting);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        step(20);
        rst = 1'b0;
        step(60);
        check("path", path_mm(), decel_path_out);
        sel_req = 3'h7;
        wait_on(0, high_speed_setting * UM_PER_MM, n);
        check("direction", dir_req, direction_out);
        sel_req = 3'h3;
        step(high_cutoff_delay * TC - 1);
        check("setpoint", high_speed_setting * UM_PER_MM, speed_setpoint_out);
        wait_on(0, mid_speed_setting * UM_PER_MM, n);
        step(8 * TC);
        check("setpoint", mid_speed_setting * UM_PER_MM, speed_setpoint_out);
        sel_req = 3'h1;
        wait_on(0, creep_speed_setting * UM_PER_MM, n);
        sel_req = 3'h0;
        wait_on(1, 0, n);
        check("current", 1'b1, motor_current_out);
        wait_on(2, 0, n);
        check_in("brake wait", 25 * TC - 2, 28 * TC + 4, n);
        check("ready", 1'b1, drive_ready_out);
        wait_on(3, 0, n);
        check_in("currentless", 2 * TC - 2, 3 * TC + 3, n);
        wait_on(4, 0, n);
        step(2);
        brake_monitor_select = 1'b1;
        contactor_monitor_select = 1'b1;
        brake_dly = 8'h0C;
        sel_req = 3'h7;
        step(6 * TC);
        sel_req = 3'h3;
        wait_on(0, creep_speed_setting * UM_PER_MM, n);
        step(8 * TC);
        sel_req = 3'h7;
        step(20 * TC);
        check("setpoint", creep_speed_setting * UM_PER_MM, speed_setpoint_out);
        sel_req = 3'h0;
        wait_on(1, 0, n);
        wait_on(2, 0, n);
        check_in("brake fb", 2 * TC - 2, 24, n);
        wait_on(3, 0, n);
        wait_on(4, 0, n);
        check_in("contactor fb", 0, 6, n);
        step(2);
        decel_mode_select = 1'b1;
        sel_req = 3'h1;
        step(10 * TC);
        check("ready", 1'b0, drive_ready_out);
        sel_req = 3'h0;
        step(20);
        decel_mode_select = 1'b0;
        decel_rate_setting = 16'h07D0;
        step(40);
        check("path", path_mm(), decel_path_out);
        results();
    end
endmodule
